// File: logic/pmsm_pkg.sv
// Constants, types and helpers shared by the power mode supply manager.
//------------------------------------------------------------------------------
// Summary of operation
// - Hold the device in static reset while the low-voltage detector reports low supply.
// - Drive the shared reset pin low while a low-voltage reset is active.
// - Single-supply: PLL at USB rate, USB interface on, core clock up to 8 MHz.
// - Single-supply: switch control unused, pin works as ordinary I/O.
// - Stand-alone: PLL off, USB off, core limited to 6 MHz, coprocessor at 6 MHz.
// - Stand-alone: supply switch control pin floats.
// - USB mode: PLL at USB rate, USB on, core up to 8 MHz, coprocessor 24 MHz.
// - USB mode: supply switch control pin driven low.
// - Plug interrupt when enabled and USB supply rises past upper threshold.
// - Reset into USB mode forces I/O to input and drives switch pin low.
// - In USB mode a fall to the lower threshold raises the plug-change interrupt when enabled.
// - Reset into stand-alone stops PLL and divides the crystal for the clock.
// - Reset into stand-alone floats I/O during reset only, and the switch pin during and after.
// - Media regulator output chosen among four voltages by a two-bit field.
// - Voltage select: 00 3.5V, 01 3.4V, 10 3.3V, 11 2.8V.
// - Plug flag follows the cable; with the interrupt enabled each edge requests an interrupt that wakes halt.
// - In USB mode the reset delay counts 256 cycles from PLL lock.
//------------------------------------------------------------------------------
package pmsm_pkg;

   //---------------------------------------------------------------------------
   // Register map
   //---------------------------------------------------------------------------
   localparam logic [7:0] OFS_POWER_CTRL = 8'h00;
   localparam logic [7:0] OFS_SEQ_CTRL   = 8'h01;
   localparam logic [7:0] OFS_SEQ_STATUS = 8'h02;

   localparam int BIT_THR_PLUS   = 7;
   localparam int BIT_THR_MINUS  = 6;
   localparam int BIT_PLUG       = 5;
   localparam int BIT_PLUG_IE    = 4;
   localparam int BIT_VSEL_LO    = 2;
   localparam int BIT_DET_OFF    = 1;
   localparam int BIT_REG_ON     = 0;
   localparam int BIT_SW_RESET   = 0;
   localparam int BIT_ST_USB     = 0;
   localparam int BIT_ST_DUAL    = 1;
   localparam int BIT_ST_LOCK    = 2;

   localparam logic [7:0] POWER_CTRL_RESET = 8'h00;
   localparam logic [1:0] VSEL_RESET       = 2'h0;

   //---------------------------------------------------------------------------
   // Reset delays and clock figures
   //---------------------------------------------------------------------------
   localparam logic [9:0] DELAY_STANDALONE = 10'h200;
   localparam logic [9:0] DELAY_USB        = 10'h100;

   localparam logic [5:0] PLL_USB_MHZ       = 6'h30;
   localparam logic [5:0] CPU_MAX_ALONE_MHZ = 6'h06;
   localparam logic [5:0] CPU_MAX_USB_MHZ   = 6'h08;
   localparam logic [5:0] XFER_ALONE_MHZ    = 6'h06;
   localparam logic [5:0] XFER_USB_MHZ      = 6'h18;

   localparam logic [11:0] MV_3V5 = 12'hdac;
   localparam logic [11:0] MV_3V4 = 12'hd48;
   localparam logic [11:0] MV_3V3 = 12'hce4;
   localparam logic [11:0] MV_2V8 = 12'haf0;

   typedef enum logic [1:0] {
      PMSM_ST_RESET     = 2'b00,
      PMSM_ST_WAIT_LOCK = 2'b01,
      PMSM_ST_DELAY     = 2'b10,
      PMSM_ST_RUN       = 2'b11
   } pmsm_state_t;

   function automatic logic [11:0] pmsm_vsel_mv(input logic [1:0] sel);
      logic [11:0] mv;
      unique case (sel)
         2'b00: mv = MV_3V5;
         2'b01: mv = MV_3V4;
         2'b10: mv = MV_3V3;
         2'b11: mv = MV_2V8;
      endcase
      return mv;
   endfunction

endpackage

// File: logic/pmsm_sync.sv
// Two-stage synchroniser for a group of asynchronous levels.
`timescale 1ns/1ps
module pmsm_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_ff;
   logic [W-1:0] q_ff;

   // The first stage feeds only the second stage.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meta_ff <= '0;
         q_ff    <= '0;
      end else begin
         meta_ff <= d;
         q_ff    <= meta_ff;
      end
   end

   assign q = q_ff;

endmodule

// File: logic/pmsm_top.sv
// Power mode supply manager: reset sequencing, supply mode and plug detection.
`timescale 1ns/1ps
module pmsm_top
   import pmsm_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   input  wire logic        lvd_supply_low,
   input  wire logic        usb_above_upper,
   input  wire logic        usb_above_lower,
   input  wire logic        pll_lock,
   input  wire logic        opt_switch_func,
   input  wire logic        rst_pin_i,
   output logic             rst_pin_o,
   output logic             rst_pin_oe,
   output logic             core_rst_n,
   output logic             io_force_input,
   output logic             pll_en,
   output logic             clk_src_pll,
   output logic             usb_if_en,
   output logic [5:0]       pll_rate_mhz,
   output logic [5:0]       cpu_clk_limit_mhz,
   output logic [5:0]       xfer_clk_mhz,
   input  wire logic        gpio_pin_o,
   input  wire logic        gpio_pin_oe,
   output logic             supply_switch_ctrl_n_o,
   output logic             supply_switch_ctrl_n_oe,
   output logic             plug_irq,
   output logic             plug_wake,
   output logic             media_regulator_on,
   output logic [1:0]       regulator_voltage_select,
   output logic [11:0]      regulator_mv
);

   //---------------------------------------------------------------------------
   // Input synchronisers
   //---------------------------------------------------------------------------
   logic [5:0] sync_q;
   logic       lvd_low_s;
   logic       upper_s;
   logic       lower_s;
   logic       lock_s;
   logic       opt_dual_s;
   logic       ext_rst_n_s;
   logic [1:0] oe_hist_ff;

   pmsm_sync #(.W(6)) u_sync (
      .clk  (clk),
      .rstn (rstn),
      .d    ({rst_pin_i, opt_switch_func, pll_lock, usb_above_lower, usb_above_upper, lvd_supply_low}),
      .q    (sync_q)
   );

   assign lvd_low_s   = sync_q[0];
   assign upper_s     = sync_q[1];
   assign lower_s     = sync_q[2];
   assign lock_s      = sync_q[3];
   assign opt_dual_s  = sync_q[4];
   // A pin still low from our own drive is not taken as an external reset.
   // The synchroniser shows that low for two cycles after we let go of the pin.
   // The mask therefore trails the drive by two cycles, or every release would restart the sequence.
   assign ext_rst_n_s = sync_q[5] | rst_pin_oe | (|oe_hist_ff);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         oe_hist_ff <= 2'h3;
      end else begin
         oe_hist_ff <= {oe_hist_ff[0], rst_pin_oe};
      end
   end

   //---------------------------------------------------------------------------
   // Registers
   //---------------------------------------------------------------------------
   pmsm_state_t state_ff;
   pmsm_state_t nxt_state;
   logic [9:0]  cnt_ff;
   logic [9:0]  nxt_cnt;
   logic        mode_usb_ff;
   logic        nxt_mode_usb;
   logic        core_rst_n_ff;
   logic        plug_ff;
   logic        nxt_plug;
   logic        plug_irq_ff;
   logic        plug_ie_ff;
   logic [1:0]  vsel_ff;
   logic        det_off_ff;
   logic        reg_on_ff;
   logic [7:0]  rdata_ff;
   logic [7:0]  nxt_rdata;

   //---------------------------------------------------------------------------
   // Register decode
   //---------------------------------------------------------------------------
   wire wr_power = reg_wr && (reg_addr == OFS_POWER_CTRL);
   wire wr_seq   = reg_wr && (reg_addr == OFS_SEQ_CTRL);
   wire sw_reset = wr_seq && reg_wdata[BIT_SW_RESET];
   wire in_reset = (state_ff == PMSM_ST_RESET);

   // Disabling the detector forces the threshold flags and the plug flag high.
   wire thr_plus  = det_off_ff | upper_s;
   wire thr_minus = det_off_ff | lower_s;

   wire [7:0] power_rd = {thr_plus, thr_minus, plug_ff, plug_ie_ff, vsel_ff, det_off_ff, reg_on_ff};
   wire [7:0] status_rd = {5'h00, lock_s, opt_dual_s, mode_usb_ff};

   assign nxt_rdata = !reg_rd                        ? 8'h00     :
                      (reg_addr == OFS_POWER_CTRL)   ? power_rd  :
                      (reg_addr == OFS_SEQ_STATUS)   ? status_rd :
                                                       8'h00;

   //---------------------------------------------------------------------------
   // Plug detection with hysteresis
   //---------------------------------------------------------------------------
   // Set on the upper threshold, clear only below the lower one.
   assign nxt_plug = det_off_ff ? 1'b1 :
                     upper_s    ? 1'b1 :
                     !lower_s   ? 1'b0 :
                                  plug_ff;

   //---------------------------------------------------------------------------
   // Reset sequencer
   //---------------------------------------------------------------------------
   wire abort = lvd_low_s | !ext_rst_n_s | sw_reset;

   // Without the switch option the part is single-supply and always runs the USB clocking.
   assign nxt_mode_usb = in_reset ? (!opt_dual_s | nxt_plug) : mode_usb_ff;

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      if (abort) begin
         nxt_state = PMSM_ST_RESET;
         nxt_cnt   = DELAY_STANDALONE;
      end else begin
         unique case (state_ff)
            PMSM_ST_RESET: begin
               if (nxt_mode_usb) begin
                  nxt_state = PMSM_ST_WAIT_LOCK;
               end else begin
                  nxt_state = PMSM_ST_DELAY;
                  nxt_cnt   = DELAY_STANDALONE;
               end
            end
            PMSM_ST_WAIT_LOCK: begin
               if (lock_s) begin
                  nxt_state = PMSM_ST_DELAY;
                  nxt_cnt   = DELAY_USB;
               end
            end
            PMSM_ST_DELAY: begin
               if (cnt_ff == 10'h001) begin
                  nxt_state = PMSM_ST_RUN;
               end
               nxt_cnt = cnt_ff - 10'h001;
            end
            PMSM_ST_RUN: begin
               nxt_state = PMSM_ST_RUN;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_ff      <= PMSM_ST_RESET;
         cnt_ff        <= DELAY_STANDALONE;
         mode_usb_ff   <= 1'b0;
         core_rst_n_ff <= 1'b0;
      end else begin
         state_ff      <= nxt_state;
         cnt_ff        <= nxt_cnt;
         mode_usb_ff   <= nxt_mode_usb;
         core_rst_n_ff <= (nxt_state == PMSM_ST_RUN);
      end
   end

   //---------------------------------------------------------------------------
   // Power control register and plug flag
   //---------------------------------------------------------------------------
   // The plug flag survives software resets so the next mode can be sampled.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         plug_ff     <= 1'b0;
         plug_irq_ff <= 1'b0;
         rdata_ff    <= 8'h00;
      end else begin
         plug_ff     <= nxt_plug;
         plug_irq_ff <= plug_ie_ff && (nxt_plug != plug_ff);
         rdata_ff    <= nxt_rdata;
      end
   end

   // Software fields return to their reset values while the sequencer is in PMSM_ST_RESET.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         plug_ie_ff <= POWER_CTRL_RESET[BIT_PLUG_IE];
         vsel_ff    <= VSEL_RESET;
         det_off_ff <= POWER_CTRL_RESET[BIT_DET_OFF];
         reg_on_ff  <= POWER_CTRL_RESET[BIT_REG_ON];
      end else if (in_reset) begin
         plug_ie_ff <= POWER_CTRL_RESET[BIT_PLUG_IE];
         vsel_ff    <= VSEL_RESET;
         det_off_ff <= POWER_CTRL_RESET[BIT_DET_OFF];
         reg_on_ff  <= POWER_CTRL_RESET[BIT_REG_ON];
      end else if (wr_power) begin
         plug_ie_ff <= reg_wdata[BIT_PLUG_IE];
         vsel_ff    <= reg_wdata[BIT_VSEL_LO +: 2];
         det_off_ff <= reg_wdata[BIT_DET_OFF];
         reg_on_ff  <= reg_wdata[BIT_REG_ON];
      end
   end

   //---------------------------------------------------------------------------
   // Outputs
   //---------------------------------------------------------------------------
   assign reg_rdata      = rdata_ff;
   assign core_rst_n     = core_rst_n_ff;
   assign io_force_input = !core_rst_n_ff;
   assign rst_pin_o      = 1'b0;
   assign rst_pin_oe     = !core_rst_n_ff;

   // The PLL follows the latched mode, so it is already starting while USB reset waits for lock.
   assign pll_en            = mode_usb_ff;
   assign clk_src_pll       = mode_usb_ff;
   assign usb_if_en         = mode_usb_ff;
   assign pll_rate_mhz      = mode_usb_ff ? PLL_USB_MHZ : 6'h00;
   assign cpu_clk_limit_mhz = mode_usb_ff ? CPU_MAX_USB_MHZ : CPU_MAX_ALONE_MHZ;
   assign xfer_clk_mhz      = mode_usb_ff ? XFER_USB_MHZ : XFER_ALONE_MHZ;

   // Single-supply parts hand the pin to the port logic; dual-supply parts own it.
   assign supply_switch_ctrl_n_o  = opt_dual_s ? 1'b0 : gpio_pin_o;
   assign supply_switch_ctrl_n_oe = opt_dual_s ? mode_usb_ff : gpio_pin_oe;

   assign plug_irq  = plug_irq_ff;
   assign plug_wake = plug_irq_ff;

   assign media_regulator_on       = reg_on_ff;
   assign regulator_voltage_select = vsel_ff;
   assign regulator_mv             = pmsm_vsel_mv(vsel_ff);

   //---------------------------------------------------------------------------
   // Assertions
   //---------------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   a_lvd_holds_reset: assert property (lvd_low_s |=> !core_rst_n && io_force_input)
      else $error("core left reset while supply low");

   a_lvd_pin_drive: assert property (lvd_low_s |=> rst_pin_oe && !rst_pin_o)
      else $error("reset pin not driven low during low-voltage reset");

   a_usb_switch_low: assert property ((opt_dual_s && mode_usb_ff) |-> (supply_switch_ctrl_n_oe && !supply_switch_ctrl_n_o))
      else $error("switch pin not low in USB mode");

   a_alone_switch_float: assert property ((opt_dual_s && !mode_usb_ff) |-> !supply_switch_ctrl_n_oe)
      else $error("switch pin driven in stand-alone mode");

   a_single_pin_gpio: assert property (!opt_dual_s |-> (supply_switch_ctrl_n_oe == gpio_pin_oe))
      else $error("switch pin not released to port logic");

   a_alone_clocks: assert property (!mode_usb_ff |-> (!pll_en && !usb_if_en && cpu_clk_limit_mhz == 6'h06 && xfer_clk_mhz == 6'h06))
      else $error("stand-alone clocking wrong");

   a_usb_clocks: assert property (mode_usb_ff |-> (pll_en && usb_if_en && cpu_clk_limit_mhz == 6'h08 && xfer_clk_mhz == 6'h18))
      else $error("USB mode clocking wrong");

   a_lock_delay_load: assert property ((state_ff == PMSM_ST_WAIT_LOCK && lock_s && !abort) |=> (state_ff == PMSM_ST_DELAY && cnt_ff == 10'h100))
      else $error("USB reset delay not loaded with 256");

   a_delay_reaches_run: assert property ((state_ff == PMSM_ST_DELAY && cnt_ff == 10'h003 && !abort) ##1 !abort ##1 !abort |=> core_rst_n)
      else $error("reset delay does not end on count");

   a_mode_held_in_run: assert property ((state_ff == PMSM_ST_RUN) |=> $stable(mode_usb_ff))
      else $error("mode changed outside reset");

   a_plug_rise_irq: assert property ((upper_s && !plug_ff && plug_ie_ff) |=> plug_irq && plug_ff)
      else $error("no interrupt on plug-in");

   a_unplug_irq: assert property ((!lower_s && !upper_s && !det_off_ff && plug_ff && plug_ie_ff) |=> plug_irq && !plug_ff)
      else $error("no interrupt on unplug");

   a_irq_needs_edge: assert property (plug_irq |-> $changed(plug_ff))
      else $error("plug interrupt without flag edge");

   a_vsel_low_volt: assert property ((vsel_ff == 2'b11) |-> (regulator_mv == 12'haf0))
      else $error("voltage select 11 not 2.8V");

   c_plug_in: cover property (plug_irq && plug_ff);
   c_sw_reset_usb: cover property (sw_reset ##[1:600] (state_ff == PMSM_ST_RUN && mode_usb_ff));
   c_sw_reset_alone: cover property (sw_reset ##[1:600] (state_ff == PMSM_ST_RUN && !mode_usb_ff));
   c_lvd_reset: cover property ((state_ff == PMSM_ST_RUN) ##1 lvd_low_s);

endmodule

// File: test/pmsm_supply_model.sv
// Model of the external USB rail, the supply switch transistor and the PLL lock detector.
`timescale 1ns/1ps
module pmsm_supply_model #(
   parameter int LOCK_CYC = 20
) (
   input  wire logic clk,
   input  wire logic cable_in,
   input  wire logic pll_en,
   input  wire logic sw_o,
   input  wire logic sw_oe,
   output logic      usb_above_upper,
   output logic      usb_above_lower,
   output logic      pll_lock,
   output logic      switch_on
);
   logic [3:0] volt_ff     = 4'h0;
   logic [7:0] lock_cnt_ff = 8'h00;
   wire        gate_level;

   // The gate has a pull-up, so a released pin leaves the switch off.
   assign gate_level      = sw_oe ? sw_o : 1'b1;
   assign switch_on       = ~gate_level;
   // The rail ramps slowly, so the two thresholds are crossed many cycles apart.
   assign usb_above_upper = volt_ff > 4'hc;
   assign usb_above_lower = volt_ff > 4'h4;
   assign pll_lock        = lock_cnt_ff == 8'(LOCK_CYC);

   always_ff @(posedge clk) begin
      if (cable_in && volt_ff != 4'hf) begin
         volt_ff <= volt_ff + 4'h1;
      end else if (!cable_in && volt_ff != 4'h0) begin
         volt_ff <= volt_ff - 4'h1;
      end
      if (!pll_en) begin
         lock_cnt_ff <= 8'h00;
      end else if (!pll_lock) begin
         lock_cnt_ff <= lock_cnt_ff + 8'h01;
      end
   end
endmodule

// File: test/tb.sv
// Self-checking bench for the power mode supply manager.
`timescale 1ns/1ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module tb;
   import pmsm_pkg::*;
   logic        clk             = 1'b0;
   logic        rstn            = 1'b0;
   logic [7:0]  reg_addr        = 8'h00;
   logic [7:0]  reg_wdata       = 8'h00;
   logic        reg_wr          = 1'b0;
   logic        reg_rd          = 1'b0;
   logic        lvd_supply_low  = 1'b0;
   logic        opt_switch_func = 1'b0;
   logic        gpio_pin_o      = 1'b0;
   logic        gpio_pin_oe     = 1'b0;
   logic        cable           = 1'b1;
   logic [7:0]  reg_rdata;
   logic        usb_above_upper, usb_above_lower, pll_lock, switch_on;
   logic        rst_pin_o, rst_pin_oe, core_rst_n, io_force_input;
   logic        pll_en, clk_src_pll, usb_if_en, plug_irq, plug_wake, media_regulator_on;
   logic [5:0]  pll_rate_mhz, cpu_clk_limit_mhz, xfer_clk_mhz;
   logic        supply_switch_ctrl_n_o, supply_switch_ctrl_n_oe;
   logic [1:0]  regulator_voltage_select;
   logic [11:0] regulator_mv;
   wire         rst_pin_i;
   int          n_mismatch      = 0;
   int          checked         = 0;

   always #50 clk = ~clk;
   // The reset pin is open drain with a pull-up.
   assign rst_pin_i = rst_pin_oe ? rst_pin_o : 1'b1;

   pmsm_top pmsm_top_inst (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .lvd_supply_low,
      .usb_above_upper, .usb_above_lower, .pll_lock, .opt_switch_func, .rst_pin_i, .rst_pin_o, .rst_pin_oe,
      .core_rst_n, .io_force_input, .pll_en, .clk_src_pll, .usb_if_en, .pll_rate_mhz, .cpu_clk_limit_mhz,
      .xfer_clk_mhz, .gpio_pin_o, .gpio_pin_oe, .supply_switch_ctrl_n_o, .supply_switch_ctrl_n_oe, .plug_irq,
      .plug_wake, .media_regulator_on, .regulator_voltage_select, .regulator_mv);
   pmsm_supply_model pmsm_supply_model_inst (.clk, .cable_in(cable), .pll_en, .sw_o(supply_switch_ctrl_n_o),
      .sw_oe(supply_switch_ctrl_n_oe), .usb_above_upper, .usb_above_lower, .pll_lock, .switch_on);

   //---------------------------------------------------------------------------
   // Bus and wait helpers
   //---------------------------------------------------------------------------
   task automatic conclude();
      $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      @(negedge clk);
      d = reg_rdata;
   endtask

   // Counts cycles until the core leaves reset; running out of the bound ends the run.
   task automatic wait_core(input int lim, output int n);
      n = 0;
      while (core_rst_n !== 1'b1) begin
         @(negedge clk);
         n++;
         if (n > lim) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, core_rst_n, 1'b1);
            conclude();
         end
      end
   endtask

   task automatic wait_irq();
      int n;
      n = 0;
      while (plug_irq !== 1'b1 && n < 100) begin
         @(negedge clk);
         n++;
      end
      `CHK(plug_irq, 1'b1)
      `CHK(plug_wake, 1'b1)
      if (n >= 100) begin
         conclude();
      end
      @(negedge clk);
      `CHK(plug_irq, 1'b0)
   endtask

   //---------------------------------------------------------------------------
   // Scenarios
   //---------------------------------------------------------------------------
   task automatic t_powerup();
      int         n;
      logic [7:0] d;
      repeat (10) @(posedge clk);
      `CHK(rst_pin_oe, 1'b1)
      rstn <= 1'b1;
      repeat (5) @(negedge clk);
      `CHK(core_rst_n, 1'b0)
      wait_core(1000, n);
      `CHK(pll_en, 1'b1)
      `CHK(usb_if_en, 1'b1)
      `CHK(pll_rate_mhz, PLL_USB_MHZ)
      `CHK(cpu_clk_limit_mhz, CPU_MAX_USB_MHZ)
      rd(OFS_POWER_CTRL, d);
      `CHK(d, 8'he0)
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         gpio_pin_o  <= i[0];
         gpio_pin_oe <= i[1];
         @(negedge clk);
         `CHK({supply_switch_ctrl_n_oe, supply_switch_ctrl_n_o}, i[1:0])
      end
   endtask

   task automatic t_lvd();
      int n;
      @(posedge clk);
      lvd_supply_low <= 1'b1;
      repeat (5) @(negedge clk);
      `CHK(rst_pin_oe, 1'b1)
      repeat (600) @(negedge clk);
      `CHK(core_rst_n, 1'b0)
      `CHK(io_force_input, 1'b1)
      @(posedge clk);
      lvd_supply_low <= 1'b0;
      wait_core(1000, n);
   endtask

   task automatic t_vsel();
      logic [11:0] mv [4];
      logic [7:0]  d;
      mv = '{MV_3V5, MV_3V4, MV_3V3, MV_2V8};
      for (int i = 0; i < 4; i++) begin
         wr(OFS_POWER_CTRL, {4'h0, i[1:0], 2'b01});
         rd(OFS_POWER_CTRL, d);
         `CHK(d & 8'h1f, {4'h0, i[1:0], 2'b01})
         `CHK(regulator_mv, mv[i])
         `CHK(media_regulator_on, 1'b1)
         `CHK(regulator_voltage_select, i[1:0])
      end
      wr(OFS_POWER_CTRL, 8'h00);
      rd(8'hff, d);
      `CHK(media_regulator_on, 1'b0)
      `CHK(d, 8'h00)
   endtask

   task automatic t_unplug();
      int         n;
      logic [7:0] d;
      @(posedge clk);
      opt_switch_func <= 1'b1;
      wr(OFS_POWER_CTRL, 8'h10);
      cable <= 1'b0;
      wait_irq();
      wr(OFS_SEQ_CTRL, 8'h01);
      repeat (3) @(negedge clk);
      `CHK(io_force_input, 1'b1)
      `CHK(supply_switch_ctrl_n_oe, 1'b0)
      wait_core(700, n);
      `CHK(supply_switch_ctrl_n_oe, 1'b0)
      `CHK(switch_on, 1'b0)
      `CHK(pll_en, 1'b0)
      `CHK(clk_src_pll, 1'b0)
      `CHK(usb_if_en, 1'b0)
      `CHK(cpu_clk_limit_mhz, CPU_MAX_ALONE_MHZ)
      `CHK(xfer_clk_mhz, XFER_ALONE_MHZ)
      rd(OFS_SEQ_STATUS, d);
      `CHK(d, 8'h02)
      wr(OFS_POWER_CTRL, 8'h02);
      rd(OFS_POWER_CTRL, d);
      `CHK(d, 8'he2)
      wr(OFS_POWER_CTRL, 8'h00);
   endtask

   task automatic t_plug();
      int         n;
      logic [7:0] d;
      wr(OFS_POWER_CTRL, 8'h10);
      cable <= 1'b1;
      wait_irq();
      wr(OFS_SEQ_CTRL, 8'h01);
      repeat (3) @(negedge clk);
      `CHK(io_force_input, 1'b1)
      `CHK({supply_switch_ctrl_n_oe, supply_switch_ctrl_n_o}, 2'b10)
      n = 0;
      while (pll_lock !== 1'b1 && n < 100) begin
         @(negedge clk);
         n++;
      end
      `CHK(pll_lock, 1'b1)
      wait_core(400, n);
      `CHK(n >= 256 && n <= 262, 1'b1)
      `CHK(pll_en, 1'b1)
      `CHK(pll_rate_mhz, PLL_USB_MHZ)
      `CHK(cpu_clk_limit_mhz, CPU_MAX_USB_MHZ)
      `CHK(xfer_clk_mhz, XFER_USB_MHZ)
      `CHK({supply_switch_ctrl_n_oe, supply_switch_ctrl_n_o}, 2'b10)
      `CHK(switch_on, 1'b1)
      rd(OFS_POWER_CTRL, d);
      `CHK(d[5], 1'b1)
      rd(OFS_SEQ_STATUS, d);
      `CHK(d, 8'h07)
   endtask

   initial begin
      t_powerup();
      t_lvd();
      t_vsel();
      t_unplug();
      t_plug();
      conclude();
   end
endmodule
